// [core/psm_power_ctrl.sv]
// Power-saving mode controller with APB register slave
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
//
// Summary of operation
// - Reset always enters Run on master clock
// - Slow enable divides clock by 2..16
// - Wait during Slow keeps divided peripheral clock
// - Wait stops CPU clock, peripherals keep running
// - Wait entry forces interrupt mask to 10
// - Wait ends on interrupt or reset
// - Interrupt entry pushes CC, loads priority mask
// - Halt with both enables clear enters Halt
// - Halt exit restarts oscillator, waits 256/4096
// - Halt entry forces mask 10, pending wakes
// - Halt stops main oscillator and processing
// - Option bit decides watchdog reset on halt
// - Opcode 8E decodes as halt instruction
// - RTC enable set selects Active-halt
// - Active-halt delay only on reset exit
// - Active-halt entry clears mask, pending wakes
// - Active-halt keeps only oscillator and RTC
// - Active-halt never causes watchdog halt reset
// - Auto-wake enable selects auto-wakeup Halt
// - RC divider expiry sets flag, wakes device
// - Reading auto-wake status clears flag, interrupt
// - Measure bit routes RC clock to capture, in Run mode only
// - Prescaler value is divide factor, zero forbidden

module psm_power_ctrl
  import psm_pkg::*;
#(
  parameter int START_DELAY_LONG = 4096
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [PSM_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  instrValid,
  input  wire logic [7:0]            instrOpcode,
  input  wire logic                  waitForInterruptInstruction,
  input  wire logic                  irqPending,
  input  wire logic                  irqHaltWake,
  input  wire logic                  rtcIrq,
  input  wire logic                  irqTake,
  input  wire logic [1:0]            irqLevel,
  input  wire logic                  ccPop,
  input  wire logic [1:0]            ccPopMask,
  input  wire logic                  watchdogEnabled,
  input  wire logic                  watchdogOnHaltOption,
  input  wire logic                  startupLongOption,
  input  wire logic                  autowakeRcClk,
  output logic                       cpuClkEn,
  output logic                       periphClkEn,
  output logic                       mainOscEn,
  output logic                       rtcClkEn,
  output logic                       autowakeRcEnable,
  output logic                       timerCaptureInputTwo,
  output logic                       autowakeIrq,
  output logic                       watchdogResetReq,
  output logic                       cpuResume,
  output psm_cc_t                    ccWrite,
  output psm_mode_t                  modeState
);

  // Elaboration check: the long start-up length
  // must fit the 13-bit start-up counter
  if (START_DELAY_LONG < 2 || START_DELAY_LONG > 8191) begin
    $error("START_DELAY_LONG out of range");
  end

  localparam logic [12:0] START_LONG_CYC = 13'(START_DELAY_LONG);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  psm_mode_t  mode_reg;
  logic [3:0] clkCtl_reg;
  logic       awEn_reg;
  logic       awMeas_reg;
  logic       awFlag_reg;
  logic [7:0] awPre_reg;
  logic [31:0] rdData_reg;

  logic [7:0] regIdx;
  logic       idxHit;
  logic       setupPh;
  logic       accessPh;
  logic       wrDone;
  logic       rdCsr;
  logic       awExpire;

  assign regIdx   = paddr[PSM_ADDR_W-1:2];
  assign idxHit   = (paddr[1:0] == 2'b00) &&
                    (regIdx == PSM_IDX_CLKCTL || regIdx == PSM_IDX_MODE ||
                     regIdx == PSM_IDX_AWSTAT || regIdx == PSM_IDX_AWPRE);
  assign setupPh  = psel && !penable;
  assign accessPh = psel && penable;
  assign wrDone   = accessPh && pwrite && idxHit;
  assign rdCsr    = accessPh && !pwrite && regIdx == PSM_IDX_AWSTAT && idxHit;
  assign pready   = accessPh;
  assign pslverr  = accessPh && !idxHit;
  assign prdata   = rdData_reg;

  // Read data is captured in the setup cycle, so one wait-free access phase
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_reg <= 32'h0000_0000;
    end else if (setupPh && !pwrite) begin
      unique case (regIdx)
        PSM_IDX_CLKCTL: rdData_reg <= {28'h000_0000, clkCtl_reg};
        PSM_IDX_MODE:   rdData_reg <= {26'h000_0000, mode_reg};
        PSM_IDX_AWSTAT: rdData_reg <= {29'h0000_0000, awFlag_reg, awMeas_reg, awEn_reg};
        PSM_IDX_AWPRE:  rdData_reg <= {24'h00_0000, awPre_reg};
        default:        rdData_reg <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clkCtl_reg <= PSM_CLKCTL_RST;
      awEn_reg   <= 1'b0;
      awMeas_reg <= 1'b0;
      awPre_reg  <= PSM_AWPRE_RST;
    end else if (wrDone) begin
      if (regIdx == PSM_IDX_CLKCTL) begin
        clkCtl_reg <= pwdata[3:0];
      end
      if (regIdx == PSM_IDX_AWSTAT) begin
        awEn_reg   <= pwdata[PSM_AW_EN_BIT];
        awMeas_reg <= pwdata[PSM_AW_MEAS_BIT];
      end
      if (regIdx == PSM_IDX_AWPRE && pwdata[7:0] != PSM_AWPRE_ZERO) begin
        awPre_reg <= pwdata[7:0];
      end
    end
  end

  // Expiry sets the flag even in the cycle a read clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      awFlag_reg <= 1'b0;
    end else if (awExpire) begin
      awFlag_reg <= 1'b1;
    end else if (rdCsr) begin
      awFlag_reg <= 1'b0;
    end
  end

  assign autowakeIrq = awFlag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Slow clock divider

  logic       slowEn;
  logic [1:0] slowSel;
  logic       rtcIe;
  logic [3:0] divCnt_reg;
  logic [3:0] divMask;
  logic       slowTick;

  assign slowEn  = clkCtl_reg[PSM_MC_SLOW_BIT];
  assign slowSel = clkCtl_reg[PSM_MC_CP_LSB +: 2];
  assign rtcIe   = clkCtl_reg[PSM_MC_RTCIE_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      divCnt_reg <= 4'h0;
    end else begin
      divCnt_reg <= divCnt_reg + 4'h1;
    end
  end

  // Divide by 2, 4, 8 or 16 gives one enable per that many master cycles
  always_comb begin
    divMask  = 4'((5'h02 << slowSel) - 5'h01);
    slowTick = !slowEn || ((divCnt_reg & divMask) == divMask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencer

  logic        haltDecoded;
  logic        haltWdgReset;
  logic        startDone;
  logic [12:0] startCnt_reg;
  logic [12:0] startLen_reg;
  psm_mode_t   mode_next;

  assign haltDecoded  = instrValid && instrOpcode == PSM_OPC_HALT;
  assign haltWdgReset = haltDecoded && watchdogEnabled && watchdogOnHaltOption &&
                        !rtcIe;
  assign startDone    = startCnt_reg == startLen_reg;

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      PSM_RUN: begin
        if (haltDecoded && !haltWdgReset) begin
          if (rtcIe) begin
            mode_next = PSM_AHALT;
          end else if (awEn_reg) begin
            mode_next = PSM_AWUHALT;
          end else begin
            mode_next = PSM_HALT;
          end
        end else if (waitForInterruptInstruction) begin
          mode_next = PSM_WAIT;
        end
      end
      PSM_WAIT: begin
        if (irqPending) begin
          mode_next = PSM_RUN;
        end
      end
      PSM_HALT: begin
        if (irqHaltWake) begin
          mode_next = PSM_STARTUP;
        end
      end
      PSM_AHALT: begin
        if (irqHaltWake || rtcIrq) begin
          mode_next = PSM_RUN;
        end
      end
      PSM_AWUHALT: begin
        if (irqHaltWake || awExpire) begin
          mode_next = PSM_STARTUP;
        end
      end
      PSM_STARTUP: begin
        if (startDone) begin
          mode_next = PSM_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= PSM_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Start-up length latched when the oscillator is restarted
  always_ff @(posedge clk) begin
    if (rst) begin
      startCnt_reg <= 13'h0000;
      startLen_reg <= PSM_START_SHORT;
    end else if (mode_reg != PSM_STARTUP) begin
      startCnt_reg <= 13'h0001;
      startLen_reg <= startupLongOption ? START_LONG_CYC : PSM_START_SHORT;
    end else begin
      startCnt_reg <= startCnt_reg + 13'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cpuResume        <= 1'b0;
      watchdogResetReq <= 1'b0;
    end else begin
      cpuResume        <= mode_reg != PSM_RUN && mode_next == PSM_RUN;
      watchdogResetReq <= mode_reg == PSM_RUN && haltWdgReset;
    end
  end

  // Mask forcing on entry; interrupt push and pop take the same path
  always_ff @(posedge clk) begin
    if (rst) begin
      ccWrite <= '0;
    end else begin
      ccWrite <= '0;
      if (mode_reg == PSM_RUN && mode_next == PSM_AHALT) begin
        ccWrite <= '{push: 1'b0, wr: 1'b1, mask: PSM_CC_CLEARED};
      end else if (mode_reg == PSM_RUN && mode_next != PSM_RUN) begin
        ccWrite <= '{push: 1'b0, wr: 1'b1, mask: PSM_CC_ALL_EN};
      end else if (irqTake) begin
        ccWrite <= '{push: 1'b1, wr: 1'b1, mask: irqLevel};
      end else if (ccPop) begin
        ccWrite <= '{push: 1'b0, wr: 1'b1, mask: ccPopMask};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gating

  logic oscOn;

  assign oscOn       = mode_reg != PSM_HALT && mode_reg != PSM_AWUHALT;
  assign mainOscEn   = oscOn;
  assign rtcClkEn    = oscOn;
  assign cpuClkEn    = mode_reg == PSM_RUN && slowTick;
  assign periphClkEn = (mode_reg == PSM_RUN || mode_reg == PSM_WAIT) && slowTick;
  assign modeState   = mode_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Auto-wakeup timer

  logic       rcPrev_reg;
  logic       rcRise;
  logic [5:0] fixCnt_reg;
  logic [7:0] preCnt_reg;
  logic       measRun;

  assign measRun          = awMeas_reg && mode_reg == PSM_RUN;
  assign autowakeRcEnable = measRun || mode_reg == PSM_AWUHALT;
  assign rcRise           = autowakeRcClk && !rcPrev_reg;
  assign awExpire         = mode_reg == PSM_AWUHALT && rcRise &&
                            fixCnt_reg == PSM_AWU_FIX_MAX && preCnt_reg == awPre_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      rcPrev_reg           <= 1'b0;
      timerCaptureInputTwo <= 1'b0;
    end else begin
      rcPrev_reg           <= autowakeRcClk;
      timerCaptureInputTwo <= measRun && autowakeRcClk;
    end
  end

  // Fixed divide by 64, then divide by the prescaler value
  always_ff @(posedge clk) begin
    if (rst || mode_reg != PSM_AWUHALT) begin
      fixCnt_reg <= 6'h00;
      preCnt_reg <= 8'h01;
    end else if (rcRise) begin
      fixCnt_reg <= fixCnt_reg + 6'h01;
      if (fixCnt_reg == PSM_AWU_FIX_MAX) begin
        preCnt_reg <= preCnt_reg + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_haltRun;
    mode_reg == PSM_RUN && haltDecoded && !haltWdgReset;
  endsequence

  a_reset_run: assert property ($past(rst) |-> mode_reg == PSM_RUN)
    else $error("mode after reset is not run");
  a_wait_cpu_off: assert property (mode_reg == PSM_WAIT |-> !cpuClkEn)
    else $error("cpu clock running in wait");
  a_wait_mask: assert property (mode_reg == PSM_RUN && mode_next == PSM_WAIT
      |=> ccWrite.wr && ccWrite.mask == PSM_CC_ALL_EN)
    else $error("wait entry did not force mask");
  a_halt_select: assert property (s_haltRun ##0 (!rtcIe && !awEn_reg)
      |=> mode_reg == PSM_HALT && !mainOscEn)
    else $error("halt not entered");
  a_ahalt_mask: assert property (s_haltRun ##0 rtcIe
      |=> mode_reg == PSM_AHALT && ccWrite.mask == PSM_CC_CLEARED && rtcClkEn)
    else $error("active halt entry wrong");
  a_start_short: assert property (mode_reg == PSM_HALT && irqHaltWake && !startupLongOption
      |=> (mode_reg == PSM_STARTUP) [*8] ##249 mode_reg == PSM_RUN)
    else $error("short start-up delay wrong");
  a_wdg_halt: assert property (mode_reg == PSM_RUN && haltDecoded && watchdogEnabled
      && watchdogOnHaltOption && !rtcIe |=> watchdogResetReq && mode_reg == PSM_RUN)
    else $error("halt watchdog reset missing");
  a_flag_read: assert property (rdCsr && !awExpire |=> !autowakeIrq)
    else $error("flag not cleared by read");
  a_awu_wake: assert property (awExpire |=> autowakeIrq && mode_reg == PSM_STARTUP)
    else $error("auto wake expiry missed");

endmodule

// [common/psm_pkg.sv]
// Package: constants, register map and carrier types of the power-mode controller
package psm_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] PSM_IDX_CLKCTL = 8'h2C;
  localparam logic [7:0] PSM_IDX_MODE   = 8'h2D;
  localparam logic [7:0] PSM_IDX_AWSTAT = 8'h2E;
  localparam logic [7:0] PSM_IDX_AWPRE  = 8'h2F;
  localparam int         PSM_ADDR_W     = 10;

  // Main clock control fields
  localparam int PSM_MC_SLOW_BIT = 0;
  localparam int PSM_MC_CP_LSB   = 1;
  localparam int PSM_MC_RTCIE_BIT = 3;

  // Auto-wakeup control/status fields
  localparam int PSM_AW_EN_BIT   = 0;
  localparam int PSM_AW_MEAS_BIT = 1;
  localparam int PSM_AW_FLAG_BIT = 2;

  // Reset values and the forbidden prescaler value
  localparam logic [3:0] PSM_CLKCTL_RST = 4'h0;
  localparam logic [7:0] PSM_AWPRE_RST  = 8'hFF;
  localparam logic [7:0] PSM_AWPRE_ZERO = 8'h00;

  // Instruction and interrupt mask codes
  localparam logic [7:0] PSM_OPC_HALT     = 8'h8E;
  localparam logic [1:0] PSM_CC_ALL_EN    = 2'b10;
  localparam logic [1:0] PSM_CC_CLEARED   = 2'b00;

  // Start-up delays in master clock cycles and fixed wake-up divider
  localparam logic [12:0] PSM_START_SHORT = 13'h0100;
  localparam logic [12:0] PSM_START_LONG  = 13'h1000;
  localparam logic [5:0]  PSM_AWU_FIX_MAX = 6'h3F;

  // Operating modes, one-hot
  typedef enum logic [5:0] {
    PSM_RUN     = 6'b00_0001,
    PSM_WAIT    = 6'b00_0010,
    PSM_HALT    = 6'b00_0100,
    PSM_AHALT   = 6'b00_1000,
    PSM_AWUHALT = 6'b01_0000,
    PSM_STARTUP = 6'b10_0000
  } psm_mode_t;

  // Condition code mask write towards the core
  typedef struct packed {
    logic       push;
    logic       wr;
    logic [1:0] mask;
  } psm_cc_t;

endpackage

// [tb/psm_core_model.sv]
// Behavioural processor core and interrupt controller facing the power-mode controller
`timescale 1ns/1ns
module psm_core_model
  import psm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       doHalt,
  input  wire logic       doWait,
  input  wire logic       cpuResume,
  output logic            instrValid,
  output logic [7:0]      instrOpcode,
  output logic            waitForInterruptInstruction,
  output logic            irqTake,
  output logic [1:0]      irqLevel,
  output logic            ccPop,
  output logic [1:0]      ccPopMask
);
  logic [1:0] popDelay;

  always_ff @(posedge clk) begin
    if (rst) begin
      instrValid <= 1'b0;
      instrOpcode <= 8'h00;
      waitForInterruptInstruction <= 1'b0;
    end else begin
      instrValid <= doHalt;
      instrOpcode <= doHalt ? PSM_OPC_HALT : 8'h00;
      waitForInterruptInstruction <= doWait;
    end
  end

  // After wake the core services the interrupt, then pops the CC later
  always_ff @(posedge clk) begin
    if (rst) begin
      irqTake <= 1'b0;
      irqLevel <= 2'b00;
      popDelay <= 2'b00;
      ccPop <= 1'b0;
      ccPopMask <= 2'b00;
    end else begin
      irqTake <= cpuResume;
      irqLevel <= 2'b01;
      popDelay <= {popDelay[0], irqTake};
      ccPop <= popDelay[1];
      ccPopMask <= 2'b10;
    end
  end
endmodule

// [tb/psm_tb.sv]
// Self-checking testbench of the power-mode controller
`timescale 1ns/1ns
module tb
  import psm_pkg::*;
;
  typedef struct packed {
    logic [7:0]  idx;
    logic [31:0] data;
    logic        err;
  } psm_row_t;

  logic                  clk, rst, psel, penable, pwrite, pready, pslverr, err, x;
  logic [PSM_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic                  doHalt, doWait, instrValid, waitPulse, irqPending, irqHaltWake, rtcIrq;
  logic                  irqTake, ccPop, wdgEn, wdgOpt, longOpt, rcClk, cpuResume;
  logic                  cpuClkEn, periphClkEn, mainOscEn, rtcClkEn, rcEnable, capTwo;
  logic                  awIrq, wdgRst;
  logic [7:0]            opcode;
  logic [1:0]            irqLevel, popMask;
  logic [2:0]            rcCnt;
  psm_cc_t               ccWrite;
  psm_mode_t             modeState;
  int                    errors, samplesChecked, n, m, i;
  psm_row_t              rows [5] = '{
    '{PSM_IDX_CLKCTL, 32'h0000_0000, 1'b0}, '{PSM_IDX_MODE, 32'h0000_0001, 1'b0},
    '{PSM_IDX_AWSTAT, 32'h0000_0000, 1'b0}, '{PSM_IDX_AWPRE, 32'h0000_00FF, 1'b0},
    '{8'h10, 32'h0000_0000, 1'b1}};

  psm_power_ctrl #(.START_DELAY_LONG(16)) u_psm_power_ctrl (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instrValid(instrValid), .instrOpcode(opcode), .waitForInterruptInstruction(waitPulse),
    .irqPending(irqPending), .irqHaltWake(irqHaltWake), .rtcIrq(rtcIrq), .irqTake(irqTake),
    .irqLevel(irqLevel), .ccPop(ccPop), .ccPopMask(popMask), .watchdogEnabled(wdgEn),
    .watchdogOnHaltOption(wdgOpt), .startupLongOption(longOpt), .autowakeRcClk(rcClk),
    .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .mainOscEn(mainOscEn),
    .rtcClkEn(rtcClkEn), .autowakeRcEnable(rcEnable), .timerCaptureInputTwo(capTwo),
    .autowakeIrq(awIrq), .watchdogResetReq(wdgRst), .cpuResume(cpuResume),
    .ccWrite(ccWrite), .modeState(modeState));

  psm_core_model u_psm_core_model (
    .clk(clk), .rst(rst), .doHalt(doHalt), .doWait(doWait), .cpuResume(cpuResume),
    .instrValid(instrValid), .instrOpcode(opcode), .waitForInterruptInstruction(waitPulse),
    .irqTake(irqTake), .irqLevel(irqLevel), .ccPop(ccPop), .ccPopMask(popMask));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // RC oscillator runs only while enabled, period six clocks
  always @(posedge clk) begin
    if (rst) begin
      rcCnt <= 3'h0;
      rcClk <= 1'b0;
    end else if (rcEnable === 1'b1) begin
      rcCnt <= (rcCnt == 3'h2) ? 3'h0 : rcCnt + 3'h1;
      if (rcCnt == 3'h2) rcClk <= ~rcClk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    chk("pready", 32'h0000_0001, 32'(pready));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task wait_mode(input psm_mode_t md, input int lim);
    int k;
    for (k = 0; k < lim && modeState !== md; k++) @(posedge clk) #1;
    chk("modeState", 32'(md), 32'(modeState));
  endtask

  task core_op(input logic h);
    @(posedge clk);
    doHalt <= h;
    doWait <= ~h;
    @(posedge clk);
    doHalt <= 1'b0;
    doWait <= 1'b0;
    @(posedge clk) #1;
  endtask

  task chk_cc(input logic [3:0] exp);
    int k;
    for (k = 0; k < 6 && ccWrite.wr !== 1'b1; k++) @(posedge clk) #1;
    chk("ccWrite", 32'(exp), 32'(ccWrite));
  endtask

  task count_en(output int c, output int p);
    c = 0;
    p = 0;
    repeat (32) begin
      @(posedge clk) #1;
      c += int'(cpuClkEn === 1'b1);
      p += int'(periphClkEn === 1'b1);
    end
  endtask

  task wrap_up;
    if (errors == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #300000;
    errors++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, psel, penable, pwrite, doHalt, doWait, irqPending, irqHaltWake, rtcIrq} = 9'h100;
    {wdgEn, wdgOpt, longOpt} = 3'h0;
    paddr = '0;
    pwdata = 32'h0000_0000;
    errors = 0;
    samplesChecked = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("modeState", 32'(PSM_RUN), 32'(modeState));
    chk("mainOscEn", 32'h0000_0001, 32'(mainOscEn));
    for (i = 0; i < 5; i++) begin
      apb(1'b0, rows[i].idx, 32'h0000_0000);
      chk("prdata", rows[i].data, rd);
      chk("pslverr", 32'(rows[i].err), 32'(err));
    end
    for (i = 0; i < 4; i++) begin
      apb(1'b1, PSM_IDX_CLKCTL, 32'(1 + 2 * i));
      count_en(n, m);
      chk("cpuClkEn ticks", 32'(32 / (2 << i)), 32'(n));
    end
    apb(1'b1, PSM_IDX_CLKCTL, 32'h0000_0003);
    core_op(1'b0);
    chk("modeState", 32'(PSM_WAIT), 32'(modeState));
    chk_cc(4'b0110);
    count_en(n, m);
    chk("cpuClkEn ticks", 32'h0000_0000, 32'(n));
    chk("periphClkEn ticks", 32'h0000_0008, 32'(m));
    @(posedge clk) irqPending <= 1'b1;
    wait_mode(PSM_RUN, 4);
    chk("cpuResume", 32'h0000_0001, 32'(cpuResume));
    @(posedge clk) irqPending <= 1'b0;
    chk_cc(4'b1101);
    apb(1'b1, PSM_IDX_CLKCTL, 32'h0000_0000);
    core_op(1'b1);
    chk("modeState", 32'(PSM_HALT), 32'(modeState));
    chk_cc(4'b0110);
    chk("osc and periph", 32'h0000_0000, 32'({mainOscEn, periphClkEn}));
    @(posedge clk) irqHaltWake <= 1'b1;
    wait_mode(PSM_STARTUP, 4);
    chk("mainOscEn", 32'h0000_0001, 32'(mainOscEn));
    n = 0;
    while (modeState === PSM_STARTUP && n < 5000) begin
      n++;
      @(posedge clk) #1;
    end
    chk("startup cycles", 32'd256, 32'(n));
    chk_cc(4'b1101);
    core_op(1'b1);
    wait_mode(PSM_STARTUP, 3);
    wait_mode(PSM_RUN, 300);
    @(posedge clk) irqHaltWake <= 1'b0;
    wdgEn <= 1'b1;
    wdgOpt <= 1'b1;
    core_op(1'b1);
    for (i = 0; i < 3 && wdgRst !== 1'b1; i++) @(posedge clk) #1;
    chk("watchdogResetReq", 32'h0000_0001, 32'(wdgRst));
    chk("modeState", 32'(PSM_RUN), 32'(modeState));
    apb(1'b1, PSM_IDX_CLKCTL, 32'h0000_0008);
    core_op(1'b1);
    chk("modeState", 32'(PSM_AHALT), 32'(modeState));
    chk_cc(4'b0100);
    repeat (3) begin
      @(posedge clk) #1;
      chk("osc rtc periph", 32'h0000_0006, 32'({mainOscEn, rtcClkEn, periphClkEn}));
      chk("watchdogResetReq", 32'h0000_0000, 32'(wdgRst));
    end
    @(posedge clk) rtcIrq <= 1'b1;
    wait_mode(PSM_RUN, 3);
    @(posedge clk) rtcIrq <= 1'b0;
    wdgEn <= 1'b0;
    apb(1'b1, PSM_IDX_CLKCTL, 32'h0000_0000);
    apb(1'b1, PSM_IDX_AWSTAT, 32'h0000_0002);
    chk("autowakeRcEnable", 32'h0000_0001, 32'(rcEnable));
    repeat (8) begin
      @(negedge clk) x = rcClk;
      @(posedge clk) #1;
      chk("timerCaptureInputTwo", 32'(x), 32'(capTwo));
    end
    apb(1'b1, PSM_IDX_AWSTAT, 32'h0000_0000);
    apb(1'b1, PSM_IDX_AWPRE, 32'h0000_0000);
    apb(1'b0, PSM_IDX_AWPRE, 32'h0000_0000);
    chk("prescaler", 32'h0000_00FF, rd);
    apb(1'b1, PSM_IDX_AWPRE, 32'h0000_0002);
    apb(1'b1, PSM_IDX_AWSTAT, 32'h0000_0001);
    @(posedge clk) longOpt <= 1'b1;
    core_op(1'b1);
    chk("modeState", 32'(PSM_AWUHALT), 32'(modeState));
    chk("osc off rc on", 32'h0000_0001, 32'({mainOscEn, rcEnable}));
    n = 0;
    while (modeState !== PSM_STARTUP && n < 900) begin
      n++;
      @(posedge clk) #1;
    end
    chk("wake delay in range", 32'h0000_0001, 32'(n >= 755 && n <= 775));
    chk("autowakeIrq", 32'h0000_0001, 32'(awIrq));
    n = 0;
    while (modeState === PSM_STARTUP && n < 100) begin
      n++;
      @(posedge clk) #1;
    end
    chk("startup cycles", 32'd16, 32'(n));
    apb(1'b0, PSM_IDX_AWSTAT, 32'h0000_0000);
    chk("awu status", 32'h0000_0005, rd);
    chk("autowakeIrq", 32'h0000_0000, 32'(awIrq));
    wrap_up();
  end
endmodule
